// [rtl/dbsp_pkg.sv]
package dbsp_pkg;
    // geometry of the port
    localparam int DATA_W     = 36;              // full 36-bit data path
    localparam int LANE_W     = 9;               // one byte lane with its parity bit
    localparam int LANES      = DATA_W / LANE_W; // lane select count
    localparam int ADDR_W     = 4;               // flop array, kept small on purpose
    localparam int DEPTH      = 1 << ADDR_W;     // words in the array
    localparam int FIFO_DEPTH = 4;               // read words queued for the output stage
    localparam int CLK_NS     = 4;               // ref_clk period
    localparam int SYNC_W     = 6 + ADDR_W + LANES + DATA_W; // width of the pin synchroniser

    typedef logic [DATA_W-1:0] dbsp_word_t;
    typedef logic [LANES-1:0]  dbsp_mask_t;
    typedef logic [ADDR_W-1:0] dbsp_addr_t;

    // reset values and fixed patterns
    localparam dbsp_word_t WORD_RESET = 36'h0;
    localparam dbsp_mask_t MASK_NONE  = 4'hf;    // every lane deselected
    localparam dbsp_mask_t MASK_ALL   = 4'h0;    // every lane written
    localparam dbsp_addr_t ADDR_LSB   = 4'h1;    // burst counter flips this bit
    localparam logic [1:0] STRAP_WAIT = 2'h3;    // cycles before the strap is caught

    // command waiting for its data phase
    typedef enum logic [1:0] {
        CMD_NONE,
        CMD_READ,
        CMD_WRITE
    } dbsp_cmd_e;
endpackage : dbsp_pkg

// [rtl/dbsp_fifo.sv]
`timescale 1ns/1ps
module dbsp_fifo #(
    parameter int WIDTH = dbsp_pkg::DATA_W,
    parameter int DEPTH = dbsp_pkg::FIFO_DEPTH
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    import dbsp_pkg::*;
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = DEPTH[PW:0];

    logic [WIDTH-1:0] mem_r   [DEPTH]; // storage slots
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [PW-1:0]    wrPtr_r, wrPtr_nxt; // next slot to fill
    logic [PW-1:0]    rdPtr_r, rdPtr_nxt; // oldest slot
    logic [PW:0]      count_r, count_nxt; // occupancy, one bit wider for full
    logic             push, pop;

    // honest flags straight from the occupancy
    assign inReady  = (count_r != FULL_CNT);
    assign outValid = (count_r != '0);
    assign outData  = mem_r[rdPtr_r];

    // pointer and occupancy update; depth is a power of two so pointers wrap
    always_comb begin
        mem_nxt   = mem_r;
        push      = inValid && inReady;
        pop       = outValid && outReady;
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        count_nxt = count_r;
        if (push) begin
            mem_nxt[wrPtr_r] = inData;
            wrPtr_nxt        = wrPtr_r + 1'b1;
        end
        if (pop) begin
            rdPtr_nxt = rdPtr_r + 1'b1;
        end
        if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    // registers only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            count_r <= count_nxt;
            mem_r   <= mem_nxt;
        end
    end
endmodule : dbsp_fifo

// [rtl/dbsp_sram_port.sv]
`timescale 1ns/1ps
module dbsp_sram_port (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 kClk,           // input clock pin
    input  wire logic                 kClkN,          // complementary input clock pin
    input  wire logic                 outClk,         // output clock pin
    input  wire logic                 outClkN,        // complementary output clock pin
    input  wire logic                 loadStrobeN,    // command strobe, low starts a burst
    input  wire logic                 rdWrSel,        // high read, low write
    input  wire logic [dbsp_pkg::ADDR_W-1:0] addrIn,  // burst start address
    input  wire logic [dbsp_pkg::DATA_W-1:0] dataIn,  // data pin, input side
    input  wire logic [dbsp_pkg::LANES-1:0]  laneWriteMaskN, // low writes that lane
    output logic      [dbsp_pkg::DATA_W-1:0] dataOut, // data pin, output side
    output logic                      dataOe          // high while driving the data pin
);
    import dbsp_pkg::*;

    logic [SYNC_W-1:0] sync1_r, sync2_r; // two-stage pin synchroniser
    logic [3:0]        prevClk_r;        // last synced clock levels for edge detect
    logic kS, kNS, oS, oNS, loadS, rdWrS;
    dbsp_addr_t addrS;
    dbsp_mask_t maskS;
    dbsp_word_t dataS;
    logic kRise, kNRise, oRise, oNRise, outEdge, idleCycle;
    logic strapDone_r, strapDone_nxt; // strap caught, edges trusted from here on

    // all pins cross as one bus; only stage two is looked at
    assign {kS, kNS, oS, oNS, loadS, rdWrS, addrS, maskS, dataS} = sync2_r;
    // edges are ignored until the strap is caught: the synchroniser leaves reset at
    // zero, so pins idling high would otherwise show a false rise after reset
    assign kRise     = kS  && !prevClk_r[3] && strapDone_r;
    assign kNRise    = kNS && !prevClk_r[2] && strapDone_r;
    assign oRise     = oS  && !prevClk_r[1] && strapDone_r;
    assign oNRise    = oNS && !prevClk_r[0] && strapDone_r;
    assign idleCycle = kRise && loadS;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_r   <= '0;
            sync2_r   <= '0;
            prevClk_r <= 4'h0;
        end else begin
            sync1_r   <= {kClk, kClkN, outClk, outClkN, loadStrobeN, rdWrSel,
                          addrIn, laneWriteMaskN, dataIn};
            sync2_r   <= sync1_r;
            prevClk_r <= {kS, kNS, oS, oNS};
        end
    end

    // strap state: caught once after release, never changes afterwards
    logic [1:0] strapCnt_r, strapCnt_nxt;
    logic       singleMode_r, singleMode_nxt;

    always_comb begin
        strapCnt_nxt   = strapCnt_r;
        strapDone_nxt  = strapDone_r;
        singleMode_nxt = singleMode_r;
        if (!strapDone_r) begin
            if (strapCnt_r == STRAP_WAIT) begin
                // wait lets the synchroniser fill before the levels are trusted
                strapDone_nxt  = 1'b1;
                singleMode_nxt = oS && oNS;
            end else begin
                strapCnt_nxt = strapCnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strapCnt_r   <= 2'h0;
            strapDone_r  <= 1'b0;
            singleMode_r <= 1'b0;
        end else begin
            strapCnt_r   <= strapCnt_nxt;
            strapDone_r  <= strapDone_nxt;
            singleMode_r <= singleMode_nxt;
        end
    end

    // in single mode the input clocks time the outputs
    assign outEdge = singleMode_r ? (kRise || kNRise) : (oRise || oNRise);

    // command, array and posted write state
    dbsp_cmd_e  cmd_r, cmd_nxt;               // command taken at the last input rise
    dbsp_addr_t cmdAddr_r, cmdAddr_nxt;       // its latched address
    logic       rdSecond_r, rdSecond_nxt;     // second read word due at next complement rise
    dbsp_addr_t rdFetch_r, rdFetch_nxt;       // its address from the burst counter
    logic       wrSecond_r, wrSecond_nxt;     // second write word due
    logic       postValid_r, postValid_nxt;   // posted write holds data
    dbsp_addr_t postAddr0_r, postAddr0_nxt;   // first and second word addresses
    dbsp_addr_t postAddr1_r, postAddr1_nxt;
    dbsp_word_t postData0_r, postData0_nxt;
    dbsp_word_t postData1_r, postData1_nxt;
    dbsp_mask_t postMask0_r, postMask0_nxt;
    dbsp_mask_t postMask1_r, postMask1_nxt;
    dbsp_word_t mem_r   [DEPTH];              // storage array
    dbsp_word_t mem_nxt [DEPTH];
    logic       commitNow;
    logic       pushValid, fifoInReady, fifoOutValid;
    dbsp_word_t pushData, fifoOut;

    // replace only the lanes whose select is low
    function automatic dbsp_word_t mergeLanes(input dbsp_word_t base, input dbsp_word_t upd,
                                              input dbsp_mask_t maskN);
        dbsp_word_t res;
        res = base;
        for (int i = 0; i < LANES; i++) begin
            if (!maskN[i]) begin
                res[i*LANE_W +: LANE_W] = upd[i*LANE_W +: LANE_W];
            end
        end
        return res;
    endfunction : mergeLanes

    // array word with the posted write laid over it
    function automatic dbsp_word_t lookup(input dbsp_addr_t a);
        dbsp_word_t w;
        w = mem_r[a];
        if (postValid_r && a == postAddr0_r) begin
            w = mergeLanes(w, postData0_r, postMask0_r);
        end
        if (postValid_r && a == postAddr1_r) begin
            w = mergeLanes(w, postData1_r, postMask1_r);
        end
        return w;
    endfunction : lookup

    assign commitNow = kRise && cmd_r == CMD_WRITE && postValid_r;

    always_comb begin
        cmd_nxt       = cmd_r;
        cmdAddr_nxt   = cmdAddr_r;
        rdSecond_nxt  = rdSecond_r;
        rdFetch_nxt   = rdFetch_r;
        wrSecond_nxt  = wrSecond_r;
        postValid_nxt = postValid_r;
        postAddr0_nxt = postAddr0_r;
        postAddr1_nxt = postAddr1_r;
        postData0_nxt = postData0_r;
        postData1_nxt = postData1_r;
        postMask0_nxt = postMask0_r;
        postMask1_nxt = postMask1_r;
        mem_nxt       = mem_r;
        pushValid     = 1'b0;
        pushData      = WORD_RESET;
        if (kRise) begin
            // data phase of the command taken one input cycle ago
            case (cmd_r)
                CMD_READ: begin
                    pushValid    = 1'b1;
                    pushData     = lookup(cmdAddr_r);
                    rdSecond_nxt = 1'b1;
                    rdFetch_nxt  = cmdAddr_r ^ ADDR_LSB;
                end
                CMD_WRITE: begin
                    // the older posted write goes to the array only now
                    if (postValid_r) begin
                        mem_nxt[postAddr0_r] = mergeLanes(mem_r[postAddr0_r], postData0_r,
                                                          postMask0_r);
                        mem_nxt[postAddr1_r] = mergeLanes(mem_r[postAddr1_r], postData1_r,
                                                          postMask1_r);
                    end
                    postValid_nxt = 1'b1;
                    postAddr0_nxt = cmdAddr_r;
                    postAddr1_nxt = cmdAddr_r ^ ADDR_LSB;
                    postData0_nxt = dataS;
                    postMask0_nxt = maskS;
                    postMask1_nxt = MASK_NONE;             // nothing until beat two
                    wrSecond_nxt  = 1'b1;
                end
                default: begin
                end
            endcase
            // new command; reads are refused while the queue is full
            if (loadS) begin
                cmd_nxt = CMD_NONE;
            end else if (rdWrS && fifoInReady) begin
                cmd_nxt     = CMD_READ;
                cmdAddr_nxt = addrS;
            end else if (!rdWrS) begin
                cmd_nxt     = CMD_WRITE;
                cmdAddr_nxt = addrS;
            end else begin
                cmd_nxt = CMD_NONE;
            end
        end
        if (kNRise) begin
            if (rdSecond_r) begin
                pushValid    = 1'b1;
                pushData     = lookup(rdFetch_r);
                rdSecond_nxt = 1'b0;
            end
            if (wrSecond_r) begin
                postData1_nxt = dataS;
                postMask1_nxt = maskS;
                wrSecond_nxt  = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmd_r       <= CMD_NONE;
            cmdAddr_r   <= '0;
            rdSecond_r  <= 1'b0;
            rdFetch_r   <= '0;
            wrSecond_r  <= 1'b0;
            postValid_r <= 1'b0;
            postAddr0_r <= '0;
            postAddr1_r <= '0;
            postData0_r <= WORD_RESET;
            postData1_r <= WORD_RESET;
            postMask0_r <= MASK_NONE;
            postMask1_r <= MASK_NONE;
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= WORD_RESET;
            end
        end else begin
            cmd_r       <= cmd_nxt;
            cmdAddr_r   <= cmdAddr_nxt;
            rdSecond_r  <= rdSecond_nxt;
            rdFetch_r   <= rdFetch_nxt;
            wrSecond_r  <= wrSecond_nxt;
            postValid_r <= postValid_nxt;
            postAddr0_r <= postAddr0_nxt;
            postAddr1_r <= postAddr1_nxt;
            postData0_r <= postData0_nxt;
            postData1_r <= postData1_nxt;
            postMask0_r <= postMask0_nxt;
            postMask1_r <= postMask1_nxt;
            mem_r       <= mem_nxt;
        end
    end

    // read words wait here until an output edge asks for them
    dbsp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rdq (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .inValid  (pushValid),
        .inReady  (fifoInReady),
        .inData   (pushData),
        .outValid (fifoOutValid),
        .outReady (outEdge),
        .outData  (fifoOut)
    );

    // output register: moves only on an output edge, so stopped clocks freeze it
    dbsp_word_t dataOut_r, dataOut_nxt;
    logic       dataOe_r, dataOe_nxt;

    always_comb begin
        dataOut_nxt = dataOut_r;
        dataOe_nxt  = dataOe_r;
        if (outEdge) begin
            if (fifoOutValid) begin
                dataOut_nxt = fifoOut;
                dataOe_nxt  = 1'b1;
            end else begin
                dataOe_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dataOut_r <= WORD_RESET;
            dataOe_r  <= 1'b0;
        end else begin
            dataOut_r <= dataOut_nxt;
            dataOe_r  <= dataOe_nxt;
        end
    end

    assign dataOut = dataOut_r;
    assign dataOe  = dataOe_r;

    a_read_first_word: assert property (@(posedge ref_clk) disable iff (rst)
        kRise && cmd_r == CMD_READ |-> pushValid && pushData == lookup(cmdAddr_r))
        else $error("first read word not fetched");
    a_burst_lsb_flip: assert property (@(posedge ref_clk) disable iff (rst)
        kRise && cmd_r == CMD_READ |=> rdSecond_r && rdFetch_r == ($past(cmdAddr_r) ^ ADDR_LSB))
        else $error("second address is not first with bit zero flipped");
    a_idle_no_cmd: assert property (@(posedge ref_clk) disable iff (rst)
        idleCycle |=> cmd_r == CMD_NONE)
        else $error("command taken with strobe high");
    a_reset_tristate: assert property (@(posedge ref_clk) disable iff (rst)
        $past(rst) |-> !dataOe)
        else $error("data driven right after reset");
    a_out_on_edge: assert property (@(posedge ref_clk) disable iff (rst)
        ($changed(dataOut) || $changed(dataOe)) |-> $past(outEdge))
        else $error("output moved without an output clock edge");
    a_standby_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !outEdge [*2] |=> $stable(dataOut) && $stable(dataOe))
        else $error("output changed while clocks stopped");
    a_beat_masks: assert property (@(posedge ref_clk) disable iff (rst)
        kNRise && wrSecond_r |=> postMask1_r == $past(maskS) && postData1_r == $past(dataS))
        else $error("second beat selects not sampled with its word");
    a_lane0_write: assert property (@(posedge ref_clk) disable iff (rst)
        commitNow && !postMask0_r[0] |->
            mem_nxt[postAddr0_r][LANE_W-1:0] == postData0_r[LANE_W-1:0])
        else $error("lane zero not written");
    a_lane3_keep: assert property (@(posedge ref_clk) disable iff (rst)
        commitNow && postMask0_r[3] |->
            mem_nxt[postAddr0_r][DATA_W-1:3*LANE_W] == mem_r[postAddr0_r][DATA_W-1:3*LANE_W])
        else $error("deselected lane three altered");
    a_none_written: assert property (@(posedge ref_clk) disable iff (rst)
        commitNow && postMask1_r == MASK_NONE |-> mem_nxt[postAddr1_r] == mem_r[postAddr1_r])
        else $error("word changed with every lane deselected");
    a_bypass_post: assert property (@(posedge ref_clk) disable iff (rst)
        kRise && cmd_r == CMD_READ && postValid_r && cmdAddr_r == postAddr0_r &&
        postMask0_r == MASK_ALL |-> pushData == postData0_r)
        else $error("read missed posted write data");
    a_strap_fixed: assert property (@(posedge ref_clk) disable iff (rst)
        strapDone_r |=> strapDone_r && $stable(singleMode_r))
        else $error("clock mode changed during operation");
endmodule : dbsp_sram_port

// [verif/dbsp_ctrl_model.sv]
`timescale 1ns/1ps
module dbsp_ctrl_model (
    input  wire logic                        ref_clk,
    input  wire logic                        singleMode,     // strap both output clocks high
    input  wire logic                        outRun,         // low stalls the output clocks
    output logic                             kClk,
    output logic                             kClkN,
    output logic                             outClk,
    output logic                             outClkN,
    output logic                             loadStrobeN,
    output logic                             rdWrSel,
    output logic [dbsp_pkg::ADDR_W-1:0]      addrIn,
    output logic [dbsp_pkg::DATA_W-1:0]      dataIn,
    output logic [dbsp_pkg::LANES-1:0]       laneWriteMaskN
);
    import dbsp_pkg::*;
    dbsp_word_t wd1;      // first beat of the write in flight
    dbsp_word_t wd2;      // second beat of the write in flight
    dbsp_mask_t wm1;      // lane selects with the first beat
    dbsp_mask_t wm2;      // lane selects with the second beat
    logic       wrPend;   // a write still owes its data beats
    logic       lastRead; // previous command was a read

    // fresh noise outside data phases, so a stale copy never passes by luck
    function automatic dbsp_word_t rnd();
        return dbsp_word_t'({$urandom(), $urandom()});
    endfunction : rnd

    // clocks parked, strap level put on the output clocks
    task automatic park();
        kClk           <= 1'b0;
        kClkN          <= 1'b1;
        outClk         <= singleMode;
        outClkN        <= 1'b1;
        loadStrobeN    <= 1'b1;
        rdWrSel        <= 1'b0;
        addrIn         <= '0;
        dataIn         <= rnd();
        laneWriteMaskN <= MASK_NONE;
        wrPend   = 1'b0;
        lastRead = 1'b0;
    endtask : park

    // one half cycle; output clocks trail the input clocks by two cycles
    task automatic phase(input logic k, input dbsp_word_t d, input dbsp_mask_t m);
        @(posedge ref_clk);
        kClk           <= k;
        kClkN          <= ~k;
        dataIn         <= d;
        laneWriteMaskN <= m;
        repeat (2) @(posedge ref_clk);
        if (singleMode) begin
            outClk  <= 1'b1;
            outClkN <= 1'b1;
        end else if (outRun) begin     // a stall simply leaves them parked
            outClk  <= k;
            outClkN <= ~k;
        end
        @(posedge ref_clk);
    endtask : phase

    // one command cycle; the previous write's beats ride on its two edges
    task automatic step(input logic ls, input logic rw, input dbsp_addr_t a,
                        input dbsp_word_t d1, input dbsp_word_t d2,
                        input dbsp_mask_t m1, input dbsp_mask_t m2);
        dbsp_word_t b1;
        dbsp_word_t b2;
        dbsp_mask_t n1;
        dbsp_mask_t n2;
        if (!ls && !rw && lastRead)
            step(1'b1, 1'b1, a, d1, d2, m1, m2);
        b1 = wrPend ? wd1 : rnd();
        b2 = wrPend ? wd2 : rnd();
        n1 = wrPend ? wm1 : dbsp_mask_t'($urandom());
        n2 = wrPend ? wm2 : dbsp_mask_t'($urandom());
        wrPend   = !ls && !rw;
        lastRead = !ls && rw;
        wd1 = d1;
        wd2 = d2;
        wm1 = m1;
        wm2 = m2;
        @(posedge ref_clk);
        loadStrobeN <= ls;
        rdWrSel     <= rw;
        addrIn      <= a;
        phase(1'b1, b1, n1);
        phase(1'b0, b2, n2);
    endtask : step
endmodule : dbsp_ctrl_model

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
    import dbsp_pkg::*;
    logic       ref_clk, rst, singleMode, outRun, dataOe;
    logic       kClk, kClkN, outClk, outClkN, loadStrobeN, rdWrSel;
    dbsp_addr_t addrIn, pAddr, aAddr;
    dbsp_word_t dataIn, dataOut, lastOut;
    dbsp_mask_t laneWriteMaskN;
    int         n_fail, cmp_count, cyc;
    int         pCmd, aCmd;        // command codes: 0 idle, 1 read, 2 write
    dbsp_word_t mem [DEPTH];       // reference array, always newest data
    dbsp_word_t q [$];             // fetched words not yet on the pins
    dbsp_word_t pd [5];            // expected data, delayed to settle
    logic       po [5];            // expected drive enable, delayed
    logic [4:0] pv;                // delayed check pending
    logic       kP, kNP, oP, oNP, kR, kNR, oE;

    dbsp_ctrl_model dbsp_ctrl_model_i (.ref_clk(ref_clk), .singleMode(singleMode),
        .outRun(outRun), .kClk(kClk), .kClkN(kClkN), .outClk(outClk), .outClkN(outClkN),
        .loadStrobeN(loadStrobeN), .rdWrSel(rdWrSel), .addrIn(addrIn), .dataIn(dataIn),
        .laneWriteMaskN(laneWriteMaskN));
    dbsp_sram_port dbsp_sram_port_i (.ref_clk(ref_clk), .rst(rst), .kClk(kClk),
        .kClkN(kClkN), .outClk(outClk), .outClkN(outClkN), .loadStrobeN(loadStrobeN),
        .rdWrSel(rdWrSel), .addrIn(addrIn), .dataIn(dataIn),
        .laneWriteMaskN(laneWriteMaskN), .dataOut(dataOut), .dataOe(dataOe));

    // 250 MHz reference clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    task automatic check(input dbsp_word_t seen, input dbsp_word_t exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one data half into the reference: read fetch or masked write
    task automatic beat(input dbsp_word_t d, input dbsp_mask_t m, input dbsp_addr_t a);
        if (aCmd == 1) q.push_back(mem[a]);
        if (aCmd == 2)
            for (int i = 0; i < LANES; i++)
                if (!m[i]) mem[a][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
    endtask : beat

    // reference model, watching the pins as the device would
    always @(posedge ref_clk) begin
        kR  = kClk & ~kP;
        kNR = kClkN & ~kNP;
        oE  = singleMode ? (kR | kNR) : ((outClk & ~oP) | (outClkN & ~oNP));
        kP  = kClk;
        kNP = kClkN;
        oP  = outClk;
        oNP = outClkN;
        if (pv[4]) begin
            check({35'h0, dataOe}, {35'h0, po[4]});
            check(dataOut, pd[4]);
        end
        for (int i = 4; i > 0; i--) begin
            pv[i] = pv[i-1];
            po[i] = po[i-1];
            pd[i] = pd[i-1];
        end
        pv[0] = 1'b0;
        if (rst) begin
            q.delete();
            foreach (mem[i]) mem[i] = WORD_RESET;
            pCmd = 0;
            aCmd = 0;
            lastOut = WORD_RESET;
            pv = '0;
        end else begin
            if (oE) begin  // output side first: in single mode a fetch shows one edge later
                po[0] = q.size() > 0;
                if (po[0]) lastOut = q.pop_front();
                pd[0] = lastOut;
                pv[0] = 1'b1;
            end
            if (kR) begin
                aCmd  = pCmd;
                aAddr = pAddr;
                beat(dataIn, laneWriteMaskN, aAddr);
                // strobe high is idle whatever the direction; a full queue refuses a read
                pCmd  = loadStrobeN ? 0 : !rdWrSel ? 2 : (q.size() < FIFO_DEPTH) ? 1 : 0;
                pAddr = addrIn;
            end
            if (kNR) beat(dataIn, laneWriteMaskN, aAddr ^ ADDR_LSB);
        end
    end

    // hang guard, well above the roughly two thousand cycles the run needs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic restart(input logic sm);
        @(posedge ref_clk);
        rst        <= 1'b1;
        singleMode <= sm;
        outRun     <= 1'b1;
        @(posedge ref_clk);
        dbsp_ctrl_model_i.park();
        @(posedge ref_clk);
        rst <= 1'b0;
        repeat (10) @(posedge ref_clk);
        check({35'h0, dataOe}, 36'h0);
        check(dataOut, WORD_RESET);
    endtask : restart

    task automatic rd(input dbsp_addr_t a);
        dbsp_ctrl_model_i.step(1'b0, 1'b1, a, WORD_RESET, WORD_RESET, MASK_NONE, MASK_NONE);
    endtask : rd

    // idle cycles with a random direction select, which must be ignored
    task automatic idle(input int n);
        repeat (n) dbsp_ctrl_model_i.step(1'b1, 1'($urandom()), dbsp_addr_t'($urandom()),
            dbsp_ctrl_model_i.rnd(), dbsp_ctrl_model_i.rnd(), MASK_ALL, MASK_ALL);
    endtask : idle

    task automatic traffic(input int n);
        repeat (n) dbsp_ctrl_model_i.step(1'($urandom() % 3 == 0), 1'($urandom()),
            dbsp_addr_t'($urandom()), dbsp_ctrl_model_i.rnd(), dbsp_ctrl_model_i.rnd(),
            dbsp_mask_t'($urandom()), dbsp_mask_t'($urandom()));
    endtask : traffic

    task automatic done(input string name);
        idle(2);
        $display("test %s over, %0d mismatches so far", name, n_fail);
    endtask : done

    initial begin
        rst = 1'b1;
        singleMode = 1'b0;
        outRun = 1'b1;
        n_fail = 0;
        cmp_count = 0;
        cyc = 0;
        pv = '0;
        void'($urandom(70));
        dbsp_ctrl_model_i.park();
        restart(1'b0);
        // even then odd start, each write followed right away by its two reads
        for (int i = 0; i < 2; i++) begin
            dbsp_ctrl_model_i.step(1'b0, 1'b0, dbsp_addr_t'(2 + 3 * i),
                dbsp_ctrl_model_i.rnd(), dbsp_ctrl_model_i.rnd(), MASK_ALL, MASK_ALL);
            rd(dbsp_addr_t'(2 + 3 * i));
            rd(dbsp_addr_t'(2 + 3 * i) ^ ADDR_LSB);
        end
        done("burst");
        // all sixteen lane patterns, a different one on each beat
        for (int i = 0; i < 16; i++)
            dbsp_ctrl_model_i.step(1'b0, 1'b0, dbsp_addr_t'(2 * (i % 8)),
                dbsp_ctrl_model_i.rnd(), dbsp_ctrl_model_i.rnd(),
                dbsp_mask_t'(i), dbsp_mask_t'(15 - i));
        for (int i = 0; i < 8; i++) rd(dbsp_addr_t'(2 * i));
        done("lanes");
        // output clocks stalled: queue fills and a third read is refused
        outRun <= 1'b0;
        rd(4'h0);
        rd(4'h2);
        idle(2);
        rd(4'h4);
        idle(2);
        outRun <= 1'b1;
        done("queue");
        // every clock stopped while a word is on the pins
        rd(4'h6);
        idle(1);
        repeat (20) @(posedge ref_clk);
        check({35'h0, dataOe}, 36'h1);
        check(dataOut, lastOut);
        done("standby");
        traffic(80);
        done("random");
        restart(1'b1);
        traffic(40);
        done("single");
        report_and_stop();
    end
endmodule : tb
